/* pkg/atus_map.svh */
// Register map, field positions and reset values of the async timer update block
// Overview of operation
// - Select bit picks I/O clock or oscillator
// - Counter write in oscillator mode sets counter busy until loaded
// - Compare write in oscillator mode sets compare busy until loaded
// - Control write in oscillator mode sets control busy until loaded
// - Counter read returns live count
// - Compare/control reads return temporary register
// - Value transfers after two oscillator rising edges in oscillator mode, at once on the I/O clock
`ifndef ATUS_MAP_SVH
`define ATUS_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ATUS_OFF_STATUS   12'h000
`define ATUS_OFF_COUNT    12'h004
`define ATUS_OFF_COMPARE  12'h008
`define ATUS_OFF_CONTROL  12'h00C
`define ATUS_OFF_IRQ_STAT 12'h010
`define ATUS_OFF_IRQ_MASK 12'h014

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define ATUS_BIT_SEL      3
`define ATUS_BIT_CNT_BUSY 2
`define ATUS_BIT_CMP_BUSY 1
`define ATUS_BIT_CTL_BUSY 0
`define ATUS_RST_BYTE     8'h00
`define ATUS_RST_WORD     32'h0000_0000
`define ATUS_EDGES_NEEDED 2'h2

`endif

/* pkg/atus_pkg.sv */
// Types shared by the async timer update block
package atus_pkg;
    // Index of each transferred register
    typedef enum logic [1:0] {
        ATUS_REG_COUNT   = 2'b00,
        ATUS_REG_COMPARE = 2'b01,
        ATUS_REG_CONTROL = 2'b10
    } atus_reg_t;
    // Transfer channel state
    typedef enum logic [1:0] {
        ATUS_IDLE  = 2'b00,
        ATUS_WAIT1 = 2'b01,
        ATUS_WAIT2 = 2'b10
    } atus_xfer_t;
endpackage

/* logic/atus_xfer_chan.sv */
// One temporary register and its oscillator-edge timed transfer
`timescale 1ns/1ps
`include "atus_map.svh"
module atus_xfer_chan #(
    parameter int WIDTH = 8              // Data width
) (
    input  wire logic             pclk,      // Bus clock
    input  wire logic             presetn,   // Async reset, low active
    input  wire logic             wr,        // Software write strobe
    input  wire logic [WIDTH-1:0] wdata,     // Written value
    input  wire logic             async_en,  // Asynchronous mode
    input  wire logic             osc_rise,  // Oscillator rising edge seen
    output logic      [WIDTH-1:0] temp_q,    // Temporary register
    output logic                  load,      // Destination load pulse
    output logic                  busy       // Transfer pending
);
    // ----------------------------------------------------------------
    // Channel state
    // ----------------------------------------------------------------
    atus_pkg::atus_xfer_t st_q;             // Current state
    atus_pkg::atus_xfer_t st_d;             // Next state

    // Next state: wait two oscillator rising edges when async
    always_comb begin
        st_d = st_q;
        case (st_q)
            atus_pkg::ATUS_IDLE:  if (wr && async_en) st_d = atus_pkg::ATUS_WAIT1;
            atus_pkg::ATUS_WAIT1: if (osc_rise) st_d = atus_pkg::ATUS_WAIT2;
            atus_pkg::ATUS_WAIT2: if (osc_rise) st_d = atus_pkg::ATUS_IDLE;
            default:              st_d = atus_pkg::ATUS_IDLE;
        endcase
        if (!async_en) st_d = atus_pkg::ATUS_IDLE;
    end

    // Load on second edge, or at once in synchronous mode
    assign load = (wr && !async_en) ||
                  (st_q == atus_pkg::ATUS_WAIT2 && osc_rise && async_en);
    assign busy = (st_q != atus_pkg::ATUS_IDLE);

    // State and temporary register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= atus_pkg::ATUS_IDLE;
            temp_q <= '0;
        end else begin
            st_q <= st_d;
            if (wr) temp_q <= wdata;
        end
    end

    // Transfer completes in two oscillator edges
    chk_busy_after_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr && async_en && st_q == atus_pkg::ATUS_IDLE) |=> busy)
        else $error("busy not set after async write");
    chk_load_ends_busy: assert property (@(posedge pclk) disable iff (!presetn)
        (load && async_en) |=> !busy)
        else $error("busy still set after load");
    chk_no_early_load: assert property (@(posedge pclk) disable iff (!presetn)
        (st_q == atus_pkg::ATUS_WAIT1 && async_en) |-> !load)
        else $error("load before second edge");
endmodule

/* logic/atus_top.sv */
// Async timer clock select, write synchronisation and status over APB
`timescale 1ns/1ps
`include "atus_map.svh"
module atus_top #(
    parameter int WIDTH = 8                  // Timer register width
) (
    input  wire logic             pclk,          // Bus clock, 10 MHz
    input  wire logic             presetn,       // Async reset, low active
    input  wire logic             psel,          // APB select
    input  wire logic             penable,       // APB enable
    input  wire logic             pwrite,        // APB write
    input  wire logic [11:0]      paddr,         // APB byte address
    input  wire logic [31:0]      pwdata,        // APB write data
    output logic      [31:0]      prdata,        // APB read data
    output logic                  pready,        // APB ready
    output logic                  pslverr,       // APB error
    input  wire logic             timer_osc_in,  // Oscillator pin
    input  wire logic [WIDTH-1:0] timer_count,   // Live count from timer
    output logic                  count_tick,    // Timer count enable pulse
    output logic      [WIDTH-1:0] count_load_val,// Counter load value
    output logic                  count_load,    // Counter load pulse
    output logic      [WIDTH-1:0] timer_compare_value, // Active compare value
    output logic      [WIDTH-1:0] timer_control, // Active control value
    output logic                  irq            // Level interrupt
);
    // ----------------------------------------------------------------
    // Oscillator pin synchroniser and edge detect
    // ----------------------------------------------------------------
    logic osc_s1_q;                          // First stage
    logic osc_s2_q;                          // Second stage
    logic osc_s3_q;                          // Previous sample
    wire  osc_rise = osc_s2_q && !osc_s3_q;  // Rising edge seen

    // Two flops before use, then edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
        end else begin
            osc_s1_q <= timer_osc_in;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
        end
    end

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    logic       sel_q;                      // Clock source select
    logic [2:0] busy;                       // Busy per channel
    logic [2:0] irq_stat_q;                 // Sticky completion flags
    logic [2:0] irq_mask_q;                 // Interrupt mask
    logic [2:0] load;                       // Load pulses
    logic [WIDTH-1:0] temp [3];             // Temporary registers
    logic [WIDTH-1:0] cmp_q;                // Active compare
    logic [WIDTH-1:0] ctl_q;                // Active control
    logic [WIDTH-1:0] cnt_val_q;            // Counter load value
    logic             cnt_load_q;           // Counter load request

    wire wr_en   = psel && penable && pwrite;              // Write access
    wire hit_st  = (paddr == `ATUS_OFF_STATUS);            // Status hit
    wire hit_cnt = (paddr == `ATUS_OFF_COUNT);             // Counter hit
    wire hit_cmp = (paddr == `ATUS_OFF_COMPARE);           // Compare hit
    wire hit_ctl = (paddr == `ATUS_OFF_CONTROL);           // Control hit
    wire hit_is  = (paddr == `ATUS_OFF_IRQ_STAT);          // Irq status hit
    wire hit_im  = (paddr == `ATUS_OFF_IRQ_MASK);          // Irq mask hit
    wire hit_any = hit_st | hit_cnt | hit_cmp | hit_ctl | hit_is | hit_im;
    wire [2:0] chan_wr = {wr_en && hit_ctl, wr_en && hit_cmp, wr_en && hit_cnt};

    wire [7:0] status_byte = {4'h0, sel_q, busy[0], busy[1], busy[2]};

    // ----------------------------------------------------------------
    // Load sources
    // ----------------------------------------------------------------
    // A synchronous write loads in its own cycle, before the temporary
    // register holds the value, so the bus data is passed straight on
    wire [WIDTH-1:0] wr_byte = pwdata[WIDTH-1:0];                                  // Written value
    wire [WIDTH-1:0] cnt_src = sel_q ? temp[atus_pkg::ATUS_REG_COUNT] : wr_byte;
    wire [WIDTH-1:0] cmp_src = sel_q ? temp[atus_pkg::ATUS_REG_COMPARE] : wr_byte;
    wire [WIDTH-1:0] ctl_src = sel_q ? temp[atus_pkg::ATUS_REG_CONTROL] : wr_byte;

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !hit_any;

    // Read mux: live count vs temporary values
    always_comb begin
        prdata = `ATUS_RST_WORD;
        if (hit_st)  prdata[7:0] = status_byte;
        if (hit_cnt) prdata[WIDTH-1:0] = timer_count;
        if (hit_cmp) prdata[WIDTH-1:0] = temp[atus_pkg::ATUS_REG_COMPARE];
        if (hit_ctl) prdata[WIDTH-1:0] = temp[atus_pkg::ATUS_REG_CONTROL];
        if (hit_is)  prdata[2:0] = irq_stat_q;
        if (hit_im)  prdata[2:0] = irq_mask_q;
    end

    // ----------------------------------------------------------------
    // Transfer channels, one per register
    // ----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            atus_xfer_chan #(.WIDTH(WIDTH)) u_chan (
                .pclk     (pclk),
                .presetn  (presetn),
                .wr       (chan_wr[gi]),
                .wdata    (pwdata[WIDTH-1:0]),
                .async_en (sel_q),
                .osc_rise (osc_rise),
                .temp_q   (temp[gi]),
                .load     (load[gi]),
                .busy     (busy[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Select bit writable, busy bits ignored on write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sel_q <= 1'b0;
        else if (wr_en && hit_st) sel_q <= pwdata[`ATUS_BIT_SEL];
    end

    // Destination registers loaded from temporaries, or from bus data when synchronous
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_q     <= '0;
            ctl_q     <= '0;
            cnt_val_q  <= '0;
            cnt_load_q <= 1'b0;
        end else begin
            if (load[atus_pkg::ATUS_REG_COMPARE]) cmp_q <= cmp_src;
            if (load[atus_pkg::ATUS_REG_CONTROL]) ctl_q <= ctl_src;
            if (load[atus_pkg::ATUS_REG_COUNT])   cnt_val_q <= cnt_src;
            cnt_load_q <= load[atus_pkg::ATUS_REG_COUNT];
        end
    end

    // Completion flags: set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 3'h0;
            irq_mask_q <= 3'h0;
        end else begin
            irq_stat_q <= (irq_stat_q & ~((wr_en && hit_is) ? pwdata[2:0] : 3'h0))
                          | (load & {3{sel_q}});
            if (wr_en && hit_im) irq_mask_q <= pwdata[2:0];
        end
    end

    // Timer ticks on its chosen clock
    assign count_tick = sel_q ? osc_rise : 1'b1;
    assign count_load          = cnt_load_q;
    assign count_load_val      = cnt_val_q;
    assign timer_compare_value = cmp_q;
    assign timer_control       = ctl_q;
    assign irq = |(irq_stat_q & irq_mask_q);

    chk_tick_source: assert property (@(posedge pclk) disable iff (!presetn)
        sel_q |-> (count_tick == osc_rise))
        else $error("tick not from oscillator");
    chk_busy_ro: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_st && busy == 3'h0) |=> (busy == 3'h0))
        else $error("busy bits written by software");
    chk_count_live: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && hit_cnt) |-> (prdata[WIDTH-1:0] == timer_count))
        else $error("count read not live");
    chk_cmp_temp: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && hit_cmp) |-> (prdata[WIDTH-1:0] == temp[atus_pkg::ATUS_REG_COMPARE]))
        else $error("compare read not temporary");
    chk_ctl_loaded: assert property (@(posedge pclk) disable iff (!presetn)
        load[atus_pkg::ATUS_REG_CONTROL] |=> (ctl_q == $past(ctl_src)))
        else $error("control not loaded");

    // ----------------------------------------------------------------
    // Checks on load path, status bits and flags
    // ----------------------------------------------------------------
    // Temporary registers capture every write, compare and control reads show them
    chk_temp_capture: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_cmp) |=> (temp[atus_pkg::ATUS_REG_COMPARE] == $past(wr_byte)))
        else $error("compare write not held");
    chk_ctl_temp: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && hit_ctl) |-> (prdata[WIDTH-1:0] == temp[atus_pkg::ATUS_REG_CONTROL]))
        else $error("control read not temporary");

    // Synchronous mode: no waiting, no busy, tick every cycle
    chk_sync_direct: assert property (@(posedge pclk) disable iff (!presetn)
        (!sel_q && wr_en && hit_cmp) |=> (cmp_q == $past(wr_byte)))
        else $error("sync compare write not loaded at once");
    chk_sync_tick: assert property (@(posedge pclk) disable iff (!presetn)
        !sel_q |-> count_tick)
        else $error("tick missing on the bus clock");
    chk_sync_no_busy: assert property (@(posedge pclk) disable iff (!presetn)
        (!sel_q && !$past(sel_q)) |-> (busy == 3'h0))
        else $error("busy set in synchronous mode");

    // Counter load request reaches the timer one cycle after the load
    chk_cnt_load_out: assert property (@(posedge pclk) disable iff (!presetn)
        load[atus_pkg::ATUS_REG_COUNT] |=>
        (count_load && count_load_val == $past(cnt_src)))
        else $error("counter load request lost");

    // Each busy flag sits at its own status bit
    chk_stat_cnt_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && hit_st) |-> (prdata[`ATUS_BIT_CNT_BUSY] == busy[atus_pkg::ATUS_REG_COUNT]))
        else $error("counter busy bit misplaced");
    chk_stat_cmp_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && hit_st) |-> (prdata[`ATUS_BIT_CMP_BUSY] == busy[atus_pkg::ATUS_REG_COMPARE]))
        else $error("compare busy bit misplaced");
    chk_stat_ctl_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && hit_st) |-> (prdata[`ATUS_BIT_CTL_BUSY] == busy[atus_pkg::ATUS_REG_CONTROL]))
        else $error("control busy bit misplaced");
    chk_sel_written: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_st) |=> (sel_q == $past(pwdata[`ATUS_BIT_SEL])))
        else $error("select bit not written");

    // Async completion sets its flag, a one written clears it
    chk_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (load[atus_pkg::ATUS_REG_COMPARE] && sel_q) |=>
        irq_stat_q[atus_pkg::ATUS_REG_COMPARE])
        else $error("compare done flag not set");
    chk_done_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_is && pwdata[atus_pkg::ATUS_REG_COMPARE] &&
         !load[atus_pkg::ATUS_REG_COMPARE]) |=> !irq_stat_q[atus_pkg::ATUS_REG_COMPARE])
        else $error("compare done flag not cleared");
endmodule

/* sim/atus_osc_model.sv */
// Crystal oscillator model driving the timer oscillator pin
`timescale 1ns/1ps
module atus_osc_model (
    input  wire logic run,  // Oscillator powered and swinging
    output logic      osc   // Pin level
);
    // ----------------------------------------
    // Free running swing, 800 ns period
    // ----------------------------------------
    // Odd start offset keeps its edges clear of the bus clock edges
    initial begin
        osc = 1'b0;
        #137;
        forever begin
            #400;
            osc = run ? ~osc : 1'b0;  // Stopped crystal rests low
        end
    end
endmodule

/* sim/atus_top_tb.sv */
// Self-checking bench for the async timer update block
`timescale 1ns/1ps
`include "atus_map.svh"
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module atus_top_tb;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic        pclk = 1'b0;      // Bus clock
    logic        presetn = 1'b0;   // Reset, low active
    logic        psel = 1'b0;      // APB select
    logic        penable = 1'b0;   // APB enable
    logic        pwrite = 1'b0;    // APB direction
    logic [11:0] paddr = 12'h000;  // APB address
    logic [31:0] pwdata = 32'h0;   // APB write data
    logic [31:0] prdata;           // APB read data
    logic        pready;           // APB ready
    logic        pslverr;          // APB error
    logic        osc;              // Oscillator pin
    logic        run = 1'b0;       // Oscillator enable
    logic [7:0]  live = 8'h00;     // Live timer count
    logic        tick, cload, irq; // Timer side strobes
    logic [7:0]  cval, cmp, ctl;   // Timer side values
    int          n_errors = 0;     // Mismatches
    int          samples_checked = 0; // Comparisons
    int          cyc = 0;          // Cycle counter
    logic [31:0] rd;               // Last read data
    logic        er;               // Last error flag
    logic [7:0]  cval_seen = 8'h00; // Last counter load value
    int          k;                // Loop counter
    always #50 pclk = ~pclk;
    atus_osc_model u_osc (.run(run), .osc(osc));
    atus_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer_osc_in(osc), .timer_count(live), .count_tick(tick),
        .count_load_val(cval), .count_load(cload), .timer_compare_value(cmp),
        .timer_control(ctl), .irq(irq));
    // ----------------------------------------
    // Bus tasks and verdict
    // ----------------------------------------
    // One APB transfer, held until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let outputs launched at the access edge settle before any compare
        @(negedge pclk);
    endtask
    // Poll status until the three busy bits drop
    task automatic wait_idle();
        k = 0;
        rd = 32'hFFFF_FFFF;
        while (rd[2:0] !== 3'h0 && k < 200) begin
            xfer(1'b0, `ATUS_OFF_STATUS, 32'h0);
            k++;
        end
    endtask
    task automatic close_out();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Record the value carried by each counter load request
    always @(posedge pclk) begin
        if (cload) cval_seen <= cval;
    end
    // Hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            close_out();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        live <= 8'h3C;
        run <= 1'b1;
        xfer(1'b0, `ATUS_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h0000_0000)
        // Synchronous mode: write lands at once, timer ticks every cycle
        xfer(1'b1, `ATUS_OFF_COMPARE, 32'h0000_005A);
        `CHK(cmp, 8'h5A)
        `CHK(tick, 1'b1)
        xfer(1'b1, `ATUS_OFF_COUNT, 32'h0000_0077);
        xfer(1'b0, `ATUS_OFF_COUNT, 32'h0);
        `CHK(rd, 32'h0000_003C)
        `CHK(cval_seen, 8'h77)
        // Switch procedure: irqs off, select crystal, rewrite all three
        xfer(1'b1, `ATUS_OFF_IRQ_MASK, 32'h0);
        xfer(1'b1, `ATUS_OFF_STATUS, 32'h0000_000F);
        xfer(1'b0, `ATUS_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h0000_0008)
        xfer(1'b1, `ATUS_OFF_COUNT, 32'h0000_0011);
        xfer(1'b1, `ATUS_OFF_COMPARE, 32'h0000_00A5);
        xfer(1'b1, `ATUS_OFF_CONTROL, 32'h0000_0042);
        xfer(1'b0, `ATUS_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h0000_000F)
        `CHK({cmp, ctl}, 16'h5A00)
        xfer(1'b0, `ATUS_OFF_COMPARE, 32'h0);
        `CHK(rd, 32'h0000_00A5)
        xfer(1'b0, `ATUS_OFF_CONTROL, 32'h0);
        `CHK(rd, 32'h0000_0042)
        wait_idle();
        `CHK(rd[2:0], 3'h0)
        `CHK({cmp, ctl}, 16'hA542)
        `CHK(cval_seen, 8'h11)
        xfer(1'b0, `ATUS_OFF_IRQ_STAT, 32'h0);
        `CHK(rd, 32'h0000_0007)
        xfer(1'b1, `ATUS_OFF_IRQ_STAT, 32'h0000_0007);
        xfer(1'b0, `ATUS_OFF_IRQ_STAT, 32'h0);
        `CHK(rd, 32'h0000_0000)
        // Unmasked compare transfer raises the interrupt
        xfer(1'b1, `ATUS_OFF_IRQ_MASK, 32'h0000_0002);
        xfer(1'b1, `ATUS_OFF_COMPARE, 32'h0000_0033);
        `CHK(irq, 1'b0)
        wait_idle();
        `CHK(irq, 1'b1)
        `CHK(cmp, 8'h33)
        xfer(1'b1, `ATUS_OFF_IRQ_STAT, 32'h0000_0002);
        `CHK(irq, 1'b0)
        // Crystal rate ticks: ten rises in 80 bus cycles
        k = 0;
        repeat (80) begin
            @(posedge pclk);
            k += tick;
        end
        `CHK(k inside {[9:11]}, 1'b1)
        // Dropping back to the bus clock abandons a pending transfer
        xfer(1'b1, `ATUS_OFF_COMPARE, 32'h0000_0066);
        xfer(1'b1, `ATUS_OFF_STATUS, 32'h0000_0000);
        xfer(1'b0, `ATUS_OFF_STATUS, 32'h0);
        `CHK(rd, 32'h0000_0000)
        `CHK(cmp, 8'h33)
        `CHK(tick, 1'b1)
        xfer(1'b0, `ATUS_OFF_COMPARE, 32'h0);
        `CHK(rd, 32'h0000_0066)
        // Unmapped place refused
        xfer(1'b0, 12'h020, 32'h0);
        `CHK({er, rd}, 33'h0_0000_0000 | 33'h1_0000_0000)
        close_out();
    end
endmodule
